// file: core/tau_clk_regs.svh
// register map, field positions and reset values of the timer clock gate
`ifndef TAU_CLK_REGS_SVH
`define TAU_CLK_REGS_SVH

`define ADDR_W                8
`define DATA_W                16

`define PER_ENABLE_OFFSET     8'h00
`define PRESCALE_SEL_OFFSET   8'h02
`define UNIT_STATUS_OFFSET    8'h04

`define PER_ENABLE_WIDTH      8
`define PER_ENABLE_RESET      8'h00
`define UNIT_CLK_EN_BIT       0

`define PRESCALE_SEL_RESET    16'h0000
`define PRESCALE_SEL_MASK     16'h33ff
`define CLK0_SEL_LSB          0
`define CLK1_SEL_LSB          4
`define CLK2_SEL_LSB          8
`define CLK3_SEL_LSB          12
`define WIDE_SEL_W            4
`define NARROW_SEL_W          2

`define PRESCALE_CNT_W        15
`define PRESCALE_TAPS         16

`define STATUS_RUN_BIT        0
`define STATUS_CLK_EN_BIT     1
`define STATUS_STATE_LSB      2
`define STATUS_CNT_LSB        12
`define STATUS_CNT_W          4

`endif

// file: core/tau_clk_pkg.sv
// types used by the timer clock gate: its gate state and its divisor code
package tau_clk_pkg;

    typedef enum logic [1:0]
    {
        unit_held    = 2'b00,
        unit_release = 2'b01,
        unit_running = 2'b10
    } unit_state_t;

    typedef logic [3:0] div_code_t;

endpackage

// file: core/prescale_if.sv
// carrier between the gate logic and the free-running prescaler counter
`include "tau_clk_regs.svh"

interface prescale_if;
    logic                          run;
    logic [`PRESCALE_CNT_W-1:0]    count;
    logic [`PRESCALE_TAPS-1:0]     tick;

    modport counter
    (
        input  run,
        output count,
        output tick
    );

    modport user
    (
        output run,
        input  count,
        input  tick
    );
endinterface

// file: core/prescale_counter.sv
// free-running prescaler counter with one tap per power-of-two divisor
`include "tau_clk_regs.svh"

module prescale_counter
(
    input  wire logic   mclk,
    input  wire logic   nrst,
    prescale_if.counter pif
);

    logic [`PRESCALE_CNT_W-1:0] count_reg;

    // counter sits at zero while the unit is held, so the phase restarts on release
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            count_reg <= '0;
        else if (!pif.run)
            count_reg <= '0;
        else
            count_reg <= count_reg + 15'h0001;
    end

    assign pif.count   = count_reg;
    assign pif.tick[0] = 1'b1;

    // tap n fires once every 2^n cycles when the low n bits are all ones
    genvar n;
    generate
        for (n = 1; n < `PRESCALE_TAPS; n = n + 1)
        begin : g_tap
            assign pif.tick[n] = &count_reg[n-1:0];
        end
    endgenerate

endmodule // prescale_counter

// file: core/timer_unit_clock_gate_prescaler.sv
// timer unit clock gate, held reset and operation clock prescaler
`include "tau_clk_regs.svh"

module timer_unit_clock_gate_prescaler
(
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic [`ADDR_W-1:0]  addr,
    input  wire logic [`DATA_W-1:0]  wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [`DATA_W-1:0]  rdata,
    output logic                     timer_unit_clk_en,
    output logic                     timer_unit_rst_n,
    output logic                     operation_clock_0,
    output logic                     operation_clock_1,
    output logic [`NARROW_SEL_W-1:0] clk2_div_select,
    output logic [`NARROW_SEL_W-1:0] clk3_div_select
);

    typedef enum logic [1:0]
    {
        sel_per    = 2'b00,
        sel_pscale = 2'b01,
        sel_status = 2'b10,
        sel_none   = 2'b11
    } reg_sel_t;

    prescale_if pif ();

    logic [`PER_ENABLE_WIDTH-1:0] per_enable_reg;
    logic [`DATA_W-1:0]           prescale_sel_reg;
    logic [`DATA_W-1:0]           prescale_sel_next;
    tau_clk_pkg::unit_state_t     unit_state_reg;
    tau_clk_pkg::unit_state_t     unit_state_next;
    logic                         clk_en_reg;
    logic                         rst_n_reg;
    logic                         op_clk0_reg;
    logic                         op_clk1_reg;
    logic [`DATA_W-1:0]           rdata_reg;
    logic [`DATA_W-1:0]           rdata_next;
    logic [`DATA_W-1:0]           status_word;
    logic                         rst_meta_n_reg;
    logic                         rst_sync_n_reg;
    logic                         gate_bit;
    logic                         unit_writable;
    logic                         per_wr;
    logic                         pscale_wr;
    tau_clk_pkg::div_code_t       clk0_code;
    tau_clk_pkg::div_code_t       clk1_code;

    // address decode shared by the write and read paths
    function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
        reg_sel_t s;
        s = sel_none;
        case (a)
            `PER_ENABLE_OFFSET:   s = sel_per;
            `PRESCALE_SEL_OFFSET: s = sel_pscale;
            `UNIT_STATUS_OFFSET:  s = sel_status;
            default:              s = sel_none;
        endcase
        return s;
    endfunction

    // picks one prescaler tap by its divisor code
    function automatic logic tap_of
    (
        input logic [`PRESCALE_TAPS-1:0] taps,
        input tau_clk_pkg::div_code_t    code
    );
        logic t;
        t = taps[code];
        return t;
    endfunction

    assign gate_bit      = per_enable_reg[`UNIT_CLK_EN_BIT];
    assign per_wr        = wr && (decode(addr) == sel_per);
    assign pscale_wr     = wr && (decode(addr) == sel_pscale);
    assign clk0_code     = prescale_sel_reg[`CLK0_SEL_LSB +: `WIDE_SEL_W];
    assign clk1_code     = prescale_sel_reg[`CLK1_SEL_LSB +: `WIDE_SEL_W];

    // unit registers only take writes once the unit is out of reset
    assign unit_writable = (unit_state_reg == tau_clk_pkg::unit_running);

    // two-flop reset synchroniser: asserts at once, releases on an edge,
    // so no flop sees the pin lift inside its recovery window
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_n_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_n_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_n_reg;
        end
    end

    // peripheral enable register sits outside the unit and is always writable
    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            per_enable_reg <= `PER_ENABLE_RESET;
        end
        else if (per_wr)
        begin
            per_enable_reg <= wdata[`PER_ENABLE_WIDTH-1:0];
        end
    end

    // gate state: held while the bit is low, one release cycle, then running
    always_comb
    begin
        unit_state_next = unit_state_reg;
        case (unit_state_reg)
            tau_clk_pkg::unit_held:
            begin
                if (gate_bit)
                    unit_state_next = tau_clk_pkg::unit_release;
            end
            tau_clk_pkg::unit_release:
            begin
                if (gate_bit)
                    unit_state_next = tau_clk_pkg::unit_running;
                else
                    unit_state_next = tau_clk_pkg::unit_held;
            end
            tau_clk_pkg::unit_running:
            begin
                if (!gate_bit)
                    unit_state_next = tau_clk_pkg::unit_held;
            end
            default:
            begin
                unit_state_next = tau_clk_pkg::unit_held;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            unit_state_reg <= tau_clk_pkg::unit_held;
        end
        else
        begin
            unit_state_reg <= unit_state_next;
        end
    end

    // clock gate follows the enable bit one cycle later, through a register
    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            clk_en_reg <= 1'b0;
        end
        else
        begin
            clk_en_reg <= gate_bit;
        end
    end

    // reset is released one cycle after the clock starts so the unit sees
    // a running clock before it leaves reset
    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_n_reg <= gate_bit && clk_en_reg;
        end
    end

    // select register: reset while held, masked writes only when running
    always_comb
    begin
        prescale_sel_next = prescale_sel_reg;
        if (unit_state_reg != tau_clk_pkg::unit_running)
            prescale_sel_next = `PRESCALE_SEL_RESET;
        else if (pscale_wr && unit_writable)
            prescale_sel_next = wdata & `PRESCALE_SEL_MASK;
    end

    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            prescale_sel_reg <= `PRESCALE_SEL_RESET;
        end
        else
        begin
            prescale_sel_reg <= prescale_sel_next;
        end
    end

    // counter runs only while the unit is out of reset
    assign pif.run = (unit_state_reg == tau_clk_pkg::unit_running);

    prescale_counter u_prescale_counter
    (
        .mclk (mclk),
        .nrst (rst_sync_n_reg),
        .pif  (pif)
    );

    // operation clocks leave as registered one-cycle enables, never as clocks,
    // which keeps every downstream flop on mclk and avoids derived clock skew
    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            op_clk0_reg <= 1'b0;
        end
        else
        begin
            op_clk0_reg <= pif.run && tap_of(pif.tick, clk0_code);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            op_clk1_reg <= 1'b0;
        end
        else
        begin
            op_clk1_reg <= pif.run && tap_of(pif.tick, clk1_code);
        end
    end

    // status word: run flag, gate flag, gate state and top counter bits,
    // so software can follow the release sequence without touching the unit
    always_comb
    begin
        status_word                                   = '0;
        status_word[`STATUS_RUN_BIT]                  = pif.run;
        status_word[`STATUS_CLK_EN_BIT]               = clk_en_reg;
        status_word[`STATUS_STATE_LSB +: 2]           = unit_state_reg;
        status_word[`STATUS_CNT_LSB +: `STATUS_CNT_W] =
            pif.count[`PRESCALE_CNT_W-1 -: `STATUS_CNT_W];
    end

    // read mux: unit registers read back their held reset value while gated
    always_comb
    begin
        rdata_next = '0;
        if (rd)
        begin
            case (decode(addr))
                sel_per:
                begin
                    rdata_next[`PER_ENABLE_WIDTH-1:0] = per_enable_reg;
                end
                sel_pscale:
                begin
                    rdata_next = prescale_sel_reg & `PRESCALE_SEL_MASK;
                end
                sel_status:
                begin
                    rdata_next = status_word;
                end
                default:
                begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata             = rdata_reg;
    assign timer_unit_clk_en = clk_en_reg;
    assign timer_unit_rst_n  = rst_n_reg;
    assign operation_clock_0 = op_clk0_reg;
    assign operation_clock_1 = op_clk1_reg;
    assign clk2_div_select   = prescale_sel_reg[`CLK2_SEL_LSB +: `NARROW_SEL_W];
    assign clk3_div_select   = prescale_sel_reg[`CLK3_SEL_LSB +: `NARROW_SEL_W];

endmodule // timer_unit_clock_gate_prescaler

// file: verification/timer_unit_clock_gate_prescaler_asserts.sv
// port-level checks for the timer clock gate and prescaler
`include "tau_clk_regs.svh"
module tucg_asserts
(
    input wire logic                     mclk,
    input wire logic                     nrst,
    input wire logic [`ADDR_W-1:0]       addr,
    input wire logic [`DATA_W-1:0]       wdata,
    input wire logic                     wr,
    input wire logic                     rd,
    input wire logic [`DATA_W-1:0]       rdata,
    input wire logic                     timer_unit_clk_en,
    input wire logic                     timer_unit_rst_n,
    input wire logic                     operation_clock_0,
    input wire logic                     operation_clock_1,
    input wire logic [`NARROW_SEL_W-1:0] clk2_div_select,
    input wire logic [`NARROW_SEL_W-1:0] clk3_div_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    gate_on_a: assert property (
        wr && addr == `PER_ENABLE_OFFSET && wdata[0]
        |=> ##1 timer_unit_clk_en ##1 timer_unit_rst_n)
        else $error("gate did not open");
    gate_off_a: assert property (
        wr && addr == `PER_ENABLE_OFFSET && !wdata[0] |=> ##1 !timer_unit_clk_en)
        else $error("gate did not close");
    held_reset_a: assert property (!timer_unit_clk_en [*2] |-> !timer_unit_rst_n)
        else $error("unit not held in reset");
    no_pulse_a: assert property (
        !timer_unit_clk_en [*3] |-> !operation_clock_0 && !operation_clock_1)
        else $error("pulse while gated");
    held_fields_a: assert property (
        !timer_unit_rst_n [*2] |-> clk2_div_select == 2'h0 && clk3_div_select == 2'h0)
        else $error("select not reset");
    locked_write_a: assert property (
        wr && addr == `PRESCALE_SEL_OFFSET && !timer_unit_rst_n
        |=> clk2_div_select == 2'h0 && clk3_div_select == 2'h0)
        else $error("write taken while held");
    read_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("rdata outside read slot");
    zero_bits_a: assert property (
        $past(rd) && $past(addr) == `PRESCALE_SEL_OFFSET |-> (rdata & ~`PRESCALE_SEL_MASK) == 0)
        else $error("fixed zero bits set");
endmodule // tucg_asserts

// file: verification/timer_unit_clock_gate_prescaler_tb.sv
// self-checking bench for the timer clock gate and prescaler
`include "tau_clk_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch at %0t got %h exp %h", $time, a, e); end end
module timer_unit_clock_gate_prescaler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        clk_en;
    logic        unit_rst_n;
    logic        op0;
    logic        op1;
    logic [1:0]  sel2;
    logic [1:0]  sel3;
    int          n_errors = 0;
    int          checked = 0;
    int          p;
    // write value, readback, clock 1 period, clock 0 period
    logic [15:0] rows [4][4] = '{'{16'h0013, 16'h0013, 16'h0002, 16'h0008},
        '{16'hff05, 16'h3305, 16'h0001, 16'h0020}, '{16'h1172, 16'h1172, 16'h0080, 16'h0004},
        '{16'hccf0, 16'h00f0, 16'h8000, 16'h0001}};

    timer_unit_clock_gate_prescaler uut
    (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_unit_clk_en(clk_en), .timer_unit_rst_n(unit_rst_n),
        .operation_clock_0(op0), .operation_clock_1(op1),
        .clk2_div_select(sel2), .clk3_div_select(sel3)
    );

    always #12.5 mclk = ~mclk;

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // pulses counted on settled samples; bound covers the slowest divisor twice
    task automatic period(input bit s, output int n);
        int k;
        k = 0;
        n = 0;
        while ((s ? op1 : op0) !== 1'b1 && k < 70000)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end while ((s ? op1 : op0) !== 1'b1 && n + k < 70000);
        // a stuck first wait lands here as well, so any hang counts
        if (n + k >= 70000)
        begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic summarize();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(`PER_ENABLE_OFFSET, 16'h0000);
        wr_reg(`PRESCALE_SEL_OFFSET, 16'h3313);
        rd_chk(`PRESCALE_SEL_OFFSET, 16'h0000);
        `CHK({clk_en, unit_rst_n}, 2'b00)
        $display("held test done");
        // select write lands before the unit runs, so it must be dropped
        wr_reg(`PER_ENABLE_OFFSET, 16'h00a5);
        wr_reg(`PRESCALE_SEL_OFFSET, 16'h3313);
        rd_chk(`PRESCALE_SEL_OFFSET, 16'h0000);
        `CHK({sel3, sel2}, 4'h0)
        rd_chk(`PER_ENABLE_OFFSET, 16'h00a5);
        `CHK({clk_en, unit_rst_n}, 2'b11)
        wr_reg(8'h40, 16'hffff);
        rd_chk(8'h40, 16'h0000);
        $display("enable test done");
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`PRESCALE_SEL_OFFSET, rows[i][0]);
            rd_chk(`PRESCALE_SEL_OFFSET, rows[i][1]);
            `CHK({sel3, sel2}, {rows[i][1][13:12], rows[i][1][9:8]})
            period(1'b1, p);
            `CHK(16'(p), rows[i][2])
            period(1'b0, p);
            `CHK(16'(p), rows[i][3])
        end
        $display("divider test done");
        wr_reg(`PER_ENABLE_OFFSET, 16'h0000);
        repeat (3) @(posedge mclk);
        #1;
        `CHK({clk_en, unit_rst_n, op0, op1}, 4'h0)
        wr_reg(`PER_ENABLE_OFFSET, 16'h0001);
        repeat (3) @(posedge mclk);
        #1;
        `CHK(op0, 1'b1)
        rd_chk(`PRESCALE_SEL_OFFSET, 16'h0000);
        $display("disable test done");
        // reset in mid-run while the unit is running with nonzero selects
        wr_reg(`PRESCALE_SEL_OFFSET, 16'h3312);
        #1;
        `CHK({sel3, sel2}, 4'hf)
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK({clk_en, unit_rst_n, op0, op1, sel3, sel2}, 8'h00)
        @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(`PER_ENABLE_OFFSET, 16'h0000);
        rd_chk(`PRESCALE_SEL_OFFSET, 16'h0000);
        $display("reset test done");
        summarize();
    end
endmodule // timer_unit_clock_gate_prescaler_tb

bind timer_unit_clock_gate_prescaler tucg_asserts chk
(
    .mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .timer_unit_clk_en, .timer_unit_rst_n,
    .operation_clock_0, .operation_clock_1, .clk2_div_select, .clk3_div_select
);
